// ===== ehn_pkg.sv
/*
 package for the erase-held nested command machine: command codes, addresses, limits, states.
 assumes a 16-bit data bus and word addresses whose low 12 bits carry the unlock offsets.
*/
package ehn_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [7:0] CMD_STAT_READ = 8'h70;
	localparam logic [7:0] CMD_STAT_CLEAR = 8'h71;
	localparam logic [7:0] CMD_SET_EXIT_ARM = 8'h90;
	localparam logic [15:0] CMD_SET_EXIT = 16'h0000;
	localparam logic [7:0] CMD_LOCK_ENTRY = 8'hA0;
	localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_ERASE_PAUSE = 8'hB0;
	localparam logic [7:0] CMD_PROG_PAUSE = 8'h51;
	localparam logic [7:0] CMD_ERASE_RESUME = 8'h30;
	localparam logic [7:0] CMD_PROG_RESUME = 8'h50;
	localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
	localparam int MAX_WORDS = 256;
	localparam int PAGE_LSB = 8;
	localparam int SECTOR_LSB = 16;
	localparam int LAT_W = 16;
	localparam int CLK_MHZ = 125;
	localparam int ESL_US = 45;
	localparam int PSL_US = 40;
	localparam int ESL_CYC = ESL_US * CLK_MHZ;
	localparam int PSL_CYC = PSL_US * CLK_MHZ;

	// one host write cycle
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ehn_wr_s;

	typedef enum logic [4:0] {
		EH_IDLE, EH_HELD, EH_HELD_STAT, EH_UNLOCK1, EH_LOCK_CMD, EH_LOCK_WRITE,
		EH_LOCK_EXIT, EH_BUF_COUNT, EH_BUF_LOAD, EH_WORD_PROG, EH_PROGRAMMING,
		EH_PROG_STAT, EH_PAUSE_PEND, EH_PAUSED, EH_PAUSED_STAT, EH_P_UNLOCK1,
		EH_P_UNLOCK2
	} ehn_state_e;
endpackage : ehn_pkg

// ===== ehn_latency.sv
/*
 down-counter that raises done a fixed number of cycles after start.
 assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ns
`default_nettype none
module ehn_latency import ehn_pkg::*; #(
	parameter int CYCLES = 16
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	output logic done
);
	localparam logic [LAT_W-1:0] LOAD = LAT_W'(CYCLES - 1);
	logic [LAT_W-1:0] count_q, count_d;
	logic run_q, run_d;

	// next count
	always_comb begin
		count_d = count_q;
		run_d = run_q;
		if (start) begin
			count_d = LOAD;
			run_d = 1'b1;
		end else if (run_q) begin
			if (count_q == '0)
				run_d = 1'b0;
			else
				count_d = count_q - 1'b1;
		end
	end

	assign done = run_q && !start && (count_q == '0);

	// register
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			count_q <= '0;
			run_q <= 1'b0;
		end else begin
			count_q <= count_d;
			run_q <= run_d;
		end
	end
endmodule : ehn_latency
`default_nettype wire

// ===== ehn_fsm.sv
/*
 command machine for the states reachable while a sector erase is held.
 assumes one write per valid pulse, a ready bit from the array, and entry from the outer machine.
*/
`timescale 1ns/1ns
`default_nettype none
module ehn_fsm import ehn_pkg::*; #(
	parameter int ESL_CYCLES = ESL_CYC,
	parameter int PSL_CYCLES = PSL_CYC,
	parameter int MAX_COUNT = MAX_WORDS
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire ehn_wr_s hostWrite,
	input wire logic enterHeld,
	input wire logic enterLockCmd,
	input wire logic enterBufCount,
	input wire logic enterWordProg,
	input wire logic [ADDR_W-1:0] bufSector,
	input wire logic deviceReadyBit,
	output ehn_state_e state,
	output logic progError,
	output logic bufWordStrobe,
	output logic lockWriteStart,
	output logic progPause,
	output logic progResume
);
	ehn_state_e state_q, state_d, ret_q, ret_d;
	logic [8:0] left_q, left_d;
	logic [ADDR_W-1:0] page_q, page_d;
	logic err_q, err_d, strobe_q, strobe_d, lock_q, lock_d, pause_q, pause_d;
	logic res_q, res_d, lockDone, pauseDone;
	logic wr, isReset, atUnl1, atUnl2;
	logic [7:0] cmd;

	// lock-operation and pause latency timers
	ehn_latency #(.CYCLES(ESL_CYCLES)) uLockLat (
		.clock(clock), .rst_b(rst_b), .start(lock_q), .done(lockDone));
	ehn_latency #(.CYCLES(PSL_CYCLES)) uPauseLat (
		.clock(clock), .rst_b(rst_b), .start(pause_q), .done(pauseDone));

	assign wr = hostWrite.valid;
	assign cmd = hostWrite.data[7:0];
	assign isReset = hostWrite.data == CMD_RESET;
	assign atUnl1 = hostWrite.addr[11:0] == ADDR_UNLOCK1;
	assign atUnl2 = hostWrite.addr[11:0] == ADDR_UNLOCK2;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		ret_d = ret_q;
		left_d = left_q;
		page_d = page_q;
		err_d = 1'b0;
		strobe_d = 1'b0;
		lock_d = 1'b0;
		pause_d = 1'b0;
		res_d = 1'b0;
		if (enterHeld)
			state_d = EH_HELD;
		else if (enterLockCmd)
			state_d = EH_LOCK_CMD;
		else if (enterBufCount)
			state_d = EH_BUF_COUNT;
		else if (enterWordProg)
			state_d = EH_WORD_PROG;
		else begin
			case (state_q)
			EH_LOCK_CMD: if (wr) begin
				if (isReset)
					state_d = EH_HELD;
				else if (atUnl1 && cmd == CMD_STAT_READ) begin
					ret_d = EH_LOCK_CMD;
					state_d = EH_HELD_STAT;
				end else if (cmd == CMD_SET_EXIT_ARM)
					state_d = EH_LOCK_EXIT;
				else if (cmd == CMD_LOCK_ENTRY)
					state_d = EH_LOCK_WRITE;
			end
			EH_LOCK_WRITE: if (wr && !lockDone)
				lock_d = 1'b1;
			else if (lockDone)
				state_d = EH_HELD;
			EH_LOCK_EXIT: if (wr && hostWrite.data == CMD_SET_EXIT)
				state_d = EH_HELD;
			EH_HELD_STAT: if (wr)
				state_d = ret_q;
			EH_BUF_COUNT: if (wr) begin
				if (32'(hostWrite.data) + 32'd1 > 32'(MAX_COUNT)
					|| hostWrite.addr[ADDR_W-1:SECTOR_LSB] != bufSector[ADDR_W-1:SECTOR_LSB]) begin
					err_d = 1'b1;
					state_d = EH_PROGRAMMING;
				end else begin
					left_d = 9'(hostWrite.data) + 9'd1;
					page_d = hostWrite.addr;
					state_d = EH_BUF_LOAD;
				end
			end
			EH_BUF_LOAD: if (wr) begin
				if (left_q == '0
					|| hostWrite.addr[ADDR_W-1:PAGE_LSB] != page_q[ADDR_W-1:PAGE_LSB]) begin
					err_d = 1'b1;
					state_d = EH_PROGRAMMING;
				end else begin
					strobe_d = 1'b1;
					left_d = left_q - 9'd1;
				end
			end
			EH_WORD_PROG: if (wr)
				state_d = EH_PROGRAMMING;
			EH_PROGRAMMING: if (wr) begin
				if (atUnl1 && cmd == CMD_STAT_READ) begin
					ret_d = EH_PROGRAMMING;
					state_d = EH_PROG_STAT;
				end else if (!deviceReadyBit) begin
					if (cmd == CMD_ERASE_PAUSE || cmd == CMD_PROG_PAUSE) begin
						pause_d = 1'b1;
						state_d = EH_PAUSE_PEND;
					end
				end else if (isReset || (atUnl1 && cmd == CMD_STAT_CLEAR))
					state_d = EH_HELD;
				else if (atUnl1 && cmd == CMD_UNLOCK1)
					state_d = EH_UNLOCK1;
			end
			EH_PROG_STAT, EH_PAUSED_STAT: begin
				// a pause that settles during the status read is not lost
				if (pauseDone && ret_q == EH_PAUSE_PEND)
					ret_d = EH_PAUSED;
				if (wr)
					state_d = ret_d;
			end
			EH_PAUSE_PEND: if (pauseDone)
				state_d = EH_PAUSED;
			else if (wr && atUnl1 && cmd == CMD_STAT_READ) begin
				ret_d = EH_PAUSE_PEND;
				state_d = EH_PROG_STAT;
			end
			EH_PAUSED, EH_P_UNLOCK2: if (wr) begin
				if (cmd == CMD_ERASE_RESUME || cmd == CMD_PROG_RESUME) begin
					res_d = 1'b1;
					state_d = EH_PROGRAMMING;
				end else if (atUnl1 && cmd == CMD_STAT_READ) begin
					ret_d = EH_PAUSED;
					state_d = EH_PAUSED_STAT;
				end else if (state_q == EH_PAUSED && atUnl1 && cmd == CMD_UNLOCK1)
					state_d = EH_P_UNLOCK1;
			end
			EH_P_UNLOCK1: if (wr) begin
				if (atUnl2 && cmd == CMD_UNLOCK2)
					state_d = EH_P_UNLOCK2;
				else if (atUnl1 && cmd == CMD_STAT_READ) begin
					ret_d = EH_PAUSED;
					state_d = EH_PAUSED_STAT;
				end
			end
			default: state_d = state_q;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_q <= EH_IDLE;
			ret_q <= EH_IDLE;
			left_q <= '0;
			page_q <= '0;
			err_q <= 1'b0;
			strobe_q <= 1'b0;
			lock_q <= 1'b0;
			pause_q <= 1'b0;
			res_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ret_q <= ret_d;
			left_q <= left_d;
			page_q <= page_d;
			err_q <= err_d;
			strobe_q <= strobe_d;
			lock_q <= lock_d;
			pause_q <= pause_d;
			res_q <= res_d;
		end
	end

	assign state = state_q;
	assign progError = err_q;
	assign bufWordStrobe = strobe_q;
	assign lockWriteStart = lock_q;
	assign progPause = pause_q;
	assign progResume = res_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_armed; state_q == EH_LOCK_EXIT; endsequence
	sequence s_exitWrite; wr && hostWrite.data == CMD_SET_EXIT && !enterHeld && !enterLockCmd
		&& !enterBufCount && !enterWordProg; endsequence

	a_lock_exit_write: assert property (s_armed ##0 s_exitWrite |=> state_q == EH_HELD)
		else $error("armed exit did not return to erase-held");
	a_lock_cmd_reset: assert property (
		state_q == EH_LOCK_CMD && wr && isReset && !enterLockCmd
		&& !enterBufCount && !enterWordProg |=> state_q == EH_HELD)
		else $error("reset did not leave lock command state");
	a_lock_auto_return: assert property (
		lockDone && state_q == EH_LOCK_WRITE && !enterLockCmd
		&& !enterBufCount && !enterWordProg |=> state_q == EH_HELD)
		else $error("lock operation did not return");
	a_count_abort: assert property (
		state_q == EH_BUF_COUNT && wr && !enterHeld && !enterLockCmd
		&& !enterBufCount && !enterWordProg && hostWrite.data >= 16'h0100
		|=> progError && state_q == EH_PROGRAMMING)
		else $error("oversize count not aborted");
	a_count_accept: assert property (
		state_q == EH_BUF_COUNT && wr && !enterHeld && !enterLockCmd
		&& !enterBufCount && !enterWordProg && hostWrite.data < 16'h0100
		&& hostWrite.addr[ADDR_W-1:SECTOR_LSB] == bufSector[ADDR_W-1:SECTOR_LSB]
		|=> state_q == EH_BUF_LOAD && !progError)
		else $error("accepted count did not start loading");
	a_load_empty: assert property (
		state_q == EH_BUF_LOAD && left_q == '0 && wr && !enterHeld
		&& !enterLockCmd && !enterBufCount && !enterWordProg |=> progError)
		else $error("load past count not aborted");
	a_load_word: assert property (
		bufWordStrobe |-> $past(state_q) == EH_BUF_LOAD
		&& left_q == $past(left_q) - 9'd1)
		else $error("word strobe without count step");
	a_pause_busy: assert property (
		progPause |-> $past(!deviceReadyBit) && state_q == EH_PAUSE_PEND)
		else $error("pause taken while ready");
	a_pause_settle: assert property (
		pauseDone && state_q == EH_PAUSE_PEND && !enterHeld
		&& !enterLockCmd && !enterBufCount && !enterWordProg |=> state_q == EH_PAUSED)
		else $error("pause pending did not settle");
	a_stat_settle: assert property (
		state_q == EH_PROG_STAT && ret_q == EH_PAUSE_PEND && pauseDone && !enterHeld
		&& !enterLockCmd && !enterBufCount && !enterWordProg |=> ret_q == EH_PAUSED)
		else $error("pause settle lost during status read");
	a_resume_code: assert property (
		progResume |-> state_q == EH_PROGRAMMING
		&& ($past(cmd) == CMD_ERASE_RESUME || $past(cmd) == CMD_PROG_RESUME))
		else $error("resume without resume code");
	a_idle_write: assert property (
		state_q == EH_PAUSED && !wr && !enterHeld && !enterLockCmd
		&& !enterBufCount && !enterWordProg |=> state_q == EH_PAUSED)
		else $error("paused state moved without write");
endmodule : ehn_fsm
`default_nettype wire

// ===== ehn_host_model.sv
/*
 host on the parallel bus: issues one write cycle per call of put.
 assumes calls come just after a falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ehn_host_model import ehn_pkg::*; (
	input wire logic clock,
	output ehn_wr_s hostWrite
);
	// ----------------------------------------
	// bus driver
	// ----------------------------------------
	initial begin
		hostWrite = '{1'b0, 24'h00_0000, 16'hFFFF};
	end

	// one write, held over one rising edge; back to back calls keep valid up
	task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		hostWrite <= '{1'b1, a, d};
		@(negedge clock);
	endtask : put

	// release: data shows the inverse so stale values never look valid
	task automatic idle;
		hostWrite <= '{1'b0, hostWrite.addr, ~hostWrite.data};
		@(negedge clock);
	endtask : idle
endmodule : ehn_host_model
`default_nettype wire

// ===== erase_held_nested_cmd_fsm_tb_top.sv
/*
 self-checking bench for the erase-held command machine.
 assumes latencies shortened to 4 cycles and inputs driven at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module erase_held_nested_cmd_fsm_tb_top import ehn_pkg::*;;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic enterHeld = 1'b0, enterLockCmd = 1'b0, enterBufCount = 1'b0, enterWordProg = 1'b0;
	logic [ADDR_W-1:0] bufSector = 24'h12_0000;
	logic deviceReadyBit = 1'b0;
	ehn_wr_s hostWrite;
	ehn_state_e state;
	logic progError, bufWordStrobe, lockWriteStart, progPause, progResume;
	int fails = 0;
	int samples_checked = 0;
	// one-hot selectors for the outer machine's entry pulses
	localparam logic [3:0] GO_HELD = 4'h8;
	localparam logic [3:0] GO_LOCK = 4'h4;
	localparam logic [3:0] GO_BUF = 4'h2;
	localparam logic [3:0] GO_WORD = 4'h1;

	// ----------------------------------------
	// clock, design and host
	// ----------------------------------------
	always #4 clock = ~clock;

	ehn_fsm #(.ESL_CYCLES(4), .PSL_CYCLES(4)) i_ehn_fsm (.clock(clock), .rst_b(rst_b),
		.hostWrite(hostWrite), .enterHeld(enterHeld), .enterLockCmd(enterLockCmd),
		.enterBufCount(enterBufCount), .enterWordProg(enterWordProg), .bufSector(bufSector),
		.deviceReadyBit(deviceReadyBit), .state(state), .progError(progError),
		.bufWordStrobe(bufWordStrobe), .lockWriteStart(lockWriteStart),
		.progPause(progPause), .progResume(progResume));
	ehn_host_model i_ehn_host_model (.clock(clock), .hostWrite(hostWrite));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		i_ehn_host_model.put(a, d);
	endtask : put

	task automatic enter(input logic [3:0] go);
		{enterHeld, enterLockCmd, enterBufCount, enterWordProg} = go;
		@(negedge clock);
		{enterHeld, enterLockCmd, enterBufCount, enterWordProg} = 4'h0;
	endtask : enter

	// bounded wait for a state reached on its own
	task automatic wait_state(input ehn_state_e s);
		for (int n = 0; n < 10 && state !== s; n++) @(negedge clock);
		check(state, s);
	endtask : wait_state

	task automatic close_out;
		if (fails == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_lock;
		enter(GO_LOCK);
		put(24'h00_0555, 16'h0071); check(state, EH_LOCK_CMD);
		put(24'h00_0555, 16'h0070); check(state, EH_HELD_STAT);
		put(24'h00_0000, 16'h0000); check(state, EH_LOCK_CMD);
		put(24'h00_0000, 16'h0090); check(state, EH_LOCK_EXIT);
		put(24'h00_0000, 16'h0000); check(state, EH_HELD);
		i_ehn_host_model.idle();
		enter(GO_LOCK);
		put(24'h00_0000, 16'h00F0); check(state, EH_HELD);
		i_ehn_host_model.idle();
		enter(GO_LOCK);
		put(24'h00_0000, 16'h00A0); check(state, EH_LOCK_WRITE);
		put(24'h03_0000, 16'h0001); check(lockWriteStart, 1'b1);
		i_ehn_host_model.idle();
		wait_state(EH_HELD);
	endtask : t_lock

	// the count write's address fixes the page that the data writes must stay in
	task automatic t_buf;
		enter(GO_BUF);
		put(24'h12_3400, 16'h0001); check(state, EH_BUF_LOAD);
		check(progError, 1'b0);
		put(24'h12_3400, 16'h0AAA); check(bufWordStrobe, 1'b1);
		put(24'h12_34FF, 16'h0BBB); check(state, EH_BUF_LOAD);
		put(24'h12_3401, 16'h0CCC); check(progError, 1'b1);
		check(state, EH_PROGRAMMING);
		i_ehn_host_model.idle();
		enter(GO_BUF);
		put(24'h12_0000, 16'h0100); check(progError, 1'b1);
		i_ehn_host_model.idle();
		enter(GO_BUF);
		put(24'h13_0000, 16'h0000); check(state, EH_PROGRAMMING);
		i_ehn_host_model.idle();
		enter(GO_BUF);
		put(24'h12_3400, 16'h00FF); check(state, EH_BUF_LOAD);
		put(24'h12_3400, 16'h0001); check(state, EH_BUF_LOAD);
		put(24'h12_3500, 16'h0002); check(progError, 1'b1);
		i_ehn_host_model.idle();
	endtask : t_buf

	task automatic t_pause;
		deviceReadyBit = 1'b0;
		enter(GO_WORD);
		put(24'h00_0100, 16'h1234); check(state, EH_PROGRAMMING);
		put(24'h00_0000, 16'h0051); check(progPause, 1'b1);
		put(24'h00_0555, 16'h0070); check(state, EH_PROG_STAT);
		repeat (6) i_ehn_host_model.idle();
		put(24'h00_0000, 16'h0000); check(state, EH_PAUSED);
		put(24'h00_0000, 16'h1234); check(state, EH_PAUSED);
		put(24'h00_0555, 16'h0070); check(state, EH_PAUSED_STAT);
		put(24'h00_0000, 16'h0000); check(state, EH_PAUSED);
		put(24'h00_0000, 16'h0030); check(progResume, 1'b1);
		put(24'h00_0555, 16'h0070); check(state, EH_PROG_STAT);
		put(24'h00_0000, 16'h0000); check(state, EH_PROGRAMMING);
		put(24'h00_0000, 16'h00B0); check(state, EH_PAUSE_PEND);
		i_ehn_host_model.idle();
		wait_state(EH_PAUSED);
		put(24'h00_0555, 16'h00AA); check(state, EH_P_UNLOCK1);
		put(24'h00_02AA, 16'h0055); check(state, EH_P_UNLOCK2);
		put(24'h00_0000, 16'h0050); check(state, EH_PROGRAMMING);
		i_ehn_host_model.idle();
		deviceReadyBit = 1'b1;
		@(negedge clock);
		put(24'h00_0555, 16'h0071); check(state, EH_HELD);
		i_ehn_host_model.idle();
		enter(GO_WORD);
		put(24'h00_0100, 16'h5678); check(state, EH_PROGRAMMING);
		put(24'h00_0000, 16'h00F0); check(state, EH_HELD);
		i_ehn_host_model.idle();
		enter(GO_WORD);
		put(24'h00_0100, 16'h5678); check(state, EH_PROGRAMMING);
		put(24'h00_0555, 16'h00AA); check(state, EH_UNLOCK1);
		i_ehn_host_model.idle();
	endtask : t_pause

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (6) @(negedge clock);
		check(state, EH_IDLE);
		rst_b = 1'b1;
		@(negedge clock);
		t_lock();
		t_buf();
		t_pause();
		enter(GO_HELD);
		check(state, EH_HELD);
		close_out();
	end

	initial begin
		#20000;
		fails++;
		close_out();
	end
endmodule : erase_held_nested_cmd_fsm_tb_top
`default_nettype wire
